// file: design/tsat_pkg.sv
// package: constants for the temperature sensor access and timeout block
package tsat_pkg;
  localparam int TSAT_CLK_MHZ = 200;
  // bus timeout window, milliseconds
  localparam int TSAT_TIMEOUT_MIN_MS = 75;
  localparam int TSAT_TIMEOUT_MAX_MS = 325;
  // 100 ms sits inside the window with margin on both sides
  localparam int TSAT_TIMEOUT_MS = 100;
  localparam longint TSAT_TIMEOUT_CYC =
    longint'(TSAT_TIMEOUT_MS) * 1000 * TSAT_CLK_MHZ;
  // conversion time, milliseconds
  localparam int TSAT_CONV_MS = 100;
  localparam longint TSAT_CONV_CYC =
    longint'(TSAT_CONV_MS) * 1000 * TSAT_CLK_MHZ;
  localparam int TSAT_TEMP_W = 9;
  localparam int TSAT_FAULT_MAX = 6;
  // power-up limits in 0.5 degree steps: 80 and 75 degrees
  localparam logic [8:0] TSAT_OVER_LIMIT_RST = 9'h0a0;
  localparam logic [8:0] TSAT_HYST_LIMIT_RST = 9'h096;
  localparam logic [8:0] TSAT_TEMP_RST = 9'h000;
  localparam logic [2:0] TSAT_FAULT_CNT_RST = 3'h1;
  localparam logic [1:0] TSAT_SYNC_RST = 2'h3;
  typedef enum logic [1:0] {
    TSAT_IDLE = 2'b00,
    TSAT_CONV = 2'b01,
    TSAT_HOLD = 2'b10
  } tsat_conv_e;
endpackage

// file: design/tsat_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module tsat_sync (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1;
  logic s2;
  logic s3;
  logic next_q;
  ////////////////////////////////////////////////////////////////////////
  // change accepted only once stages two and three agree
  always_comb begin
    next_q = q_out;
    if (s2 == s3) begin
      next_q = s2;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      q_out <= 1'b1;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      q_out <= next_q;
    end
  end
endmodule

// file: design/tsat_top.sv
// access scheduling, fault queue and stuck-data timeout
`timescale 1ns/1ps
module tsat_top #(
  parameter longint TIMEOUT_CYC = tsat_pkg::TSAT_TIMEOUT_CYC,
  parameter longint CONV_CYC = tsat_pkg::TSAT_CONV_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic SDA_IN,
  input wire logic BUS_BUSY_IN,
  input wire logic SHUTDOWN_IN,
  input wire logic [tsat_pkg::TSAT_TEMP_W-1:0] SAMPLE_IN,
  input wire logic LIMIT_WE_IN,
  input wire logic [tsat_pkg::TSAT_TEMP_W-1:0] OVER_LIMIT_IN,
  input wire logic [tsat_pkg::TSAT_TEMP_W-1:0] HYST_LIMIT_IN,
  input wire logic FAULT_WE_IN,
  input wire logic [2:0] FAULT_COUNT_IN,
  output logic [tsat_pkg::TSAT_TEMP_W-1:0] TEMP_OUT,
  output logic [tsat_pkg::TSAT_TEMP_W-1:0] OVER_LIMIT_OUT,
  output logic [tsat_pkg::TSAT_TEMP_W-1:0] HYST_LIMIT_OUT,
  output logic CONV_DONE_OUT,
  output logic OVER_TEMP_OUT,
  output logic BUS_RESET_OUT
);
  import tsat_pkg::*;
  logic sda;
  logic busy;
  logic busy_q;
  logic [40:0] low_cnt;
  logic [40:0] next_low_cnt;
  logic next_bus_reset;
  logic [40:0] conv_cnt;
  logic [40:0] next_conv_cnt;
  tsat_conv_e state;
  tsat_conv_e next_state;
  logic [TSAT_TEMP_W-1:0] next_temp;
  logic next_done;
  logic [TSAT_TEMP_W-1:0] next_over;
  logic [TSAT_TEMP_W-1:0] next_hyst;
  logic [2:0] fault_req;
  logic [2:0] next_fault_req;
  logic [2:0] fault_run;
  logic [2:0] next_fault_run;
  logic next_over_temp;
  logic over;
  logic under;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the data line and the access flag come off the bus
  tsat_sync u_sda_sync (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .d_in(SDA_IN),
    .q_out(sda)
  );
  tsat_sync u_busy_sync (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .d_in(~BUS_BUSY_IN),
    .q_out(busy_q)
  );
  assign busy = ~busy_q;

  ////////////////////////////////////////////////////////////////////////
  // stuck-data timeout: one-cycle release pulse toward the serial slave
  always_comb begin
    next_low_cnt = low_cnt;
    next_bus_reset = 1'b0;
    if (sda || SHUTDOWN_IN) begin
      next_low_cnt = '0;
    end else if (low_cnt == 41'(TIMEOUT_CYC - 1)) begin
      next_low_cnt = low_cnt + 41'h1; // fire once per low period
      next_bus_reset = 1'b1;
    end else if (low_cnt < 41'(TIMEOUT_CYC - 1)) begin
      next_low_cnt = low_cnt + 41'h1;
    end
  end
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      low_cnt <= '0;
      BUS_RESET_OUT <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      BUS_RESET_OUT <= next_bus_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion scheduler: accesses preempt, result commits only on finish
  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_temp = TEMP_OUT;
    next_done = 1'b0;
    unique case (state)
      TSAT_IDLE: begin
        next_state = busy ? TSAT_HOLD : TSAT_CONV;
        next_conv_cnt = '0;
      end
      TSAT_CONV: begin
        if (busy) begin
          next_state = TSAT_HOLD;
          next_conv_cnt = '0;
        end else if (conv_cnt == 41'(CONV_CYC - 1)) begin
          next_temp = SAMPLE_IN; // commit completed conversion
          next_done = 1'b1;
          next_conv_cnt = '0; // free-running, back to back
        end else begin
          next_conv_cnt = conv_cnt + 41'h1;
        end
      end
      TSAT_HOLD: begin
        if (!busy) begin
          next_state = TSAT_CONV;
          next_conv_cnt = '0;
        end
      end
      default: begin
        next_state = TSAT_IDLE;
      end
    endcase
  end
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state <= TSAT_IDLE;
      conv_cnt <= '0;
      TEMP_OUT <= TSAT_TEMP_RST;
      CONV_DONE_OUT <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      TEMP_OUT <= next_temp;
      CONV_DONE_OUT <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limits and fault queue; signed compares, comparator-style output
  assign over = $signed(SAMPLE_IN) > $signed(OVER_LIMIT_OUT);
  assign under = $signed(SAMPLE_IN) < $signed(HYST_LIMIT_OUT);
  always_comb begin
    next_over = OVER_LIMIT_OUT;
    next_hyst = HYST_LIMIT_OUT;
    next_fault_req = fault_req;
    next_fault_run = fault_run;
    next_over_temp = OVER_TEMP_OUT;
    if (LIMIT_WE_IN) begin
      next_over = OVER_LIMIT_IN;
      next_hyst = HYST_LIMIT_IN;
    end
    if (FAULT_WE_IN) begin
      // out-of-range counts clamp into 1..6
      if (FAULT_COUNT_IN == 3'h0) begin
        next_fault_req = 3'h1;
      end else if (FAULT_COUNT_IN > 3'(TSAT_FAULT_MAX)) begin
        next_fault_req = 3'(TSAT_FAULT_MAX);
      end else begin
        next_fault_req = FAULT_COUNT_IN;
      end
    end
    // only completed conversions feed the queue
    if (state == TSAT_CONV && !busy && conv_cnt == 41'(CONV_CYC - 1)) begin
      if (over) begin
        if (fault_run < 3'(TSAT_FAULT_MAX)) begin
          next_fault_run = fault_run + 3'h1;
        end
        if (fault_run + 3'h1 >= fault_req) begin
          next_over_temp = 1'b1;
        end
      end else begin
        next_fault_run = 3'h0;
        if (under) begin
          next_over_temp = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      OVER_LIMIT_OUT <= TSAT_OVER_LIMIT_RST;
      HYST_LIMIT_OUT <= TSAT_HYST_LIMIT_RST;
      fault_req <= TSAT_FAULT_CNT_RST;
      fault_run <= 3'h0;
      OVER_TEMP_OUT <= 1'b0;
    end else begin
      OVER_LIMIT_OUT <= next_over;
      HYST_LIMIT_OUT <= next_hyst;
      fault_req <= next_fault_req;
      fault_run <= next_fault_run;
      OVER_TEMP_OUT <= next_over_temp;
    end
  end
endmodule

// file: verification/tsat_host.sv
// host model: drives the data line and the access window
`timescale 1ns/1ps
module tsat_host (
  input wire logic clk_in,
  output logic sda_out,
  output logic busy_out
);
  // bus idles released, pulled up
  initial begin
    sda_out = 1'b1;
    busy_out = 1'b0;
  end
  // one access; data toggles so it never sits low for long
  task automatic access(input int n, input int gap);
    @(posedge clk_in);
    busy_out <= 1'b1;
    sda_out <= 1'b0;
    repeat (n) @(posedge clk_in) sda_out <= ~sda_out;
    @(posedge clk_in);
    busy_out <= 1'b0;
    sda_out <= 1'b1;
    repeat (gap) @(posedge clk_in); // caller picks the rest time
  endtask
  // stuck transfer: data held low, then back to the pull-up level
  task automatic stick(input int n);
    @(posedge clk_in);
    sda_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    sda_out <= 1'b1;
  endtask
endmodule

// file: verification/tsat_top_properties.sv
// checker: timing relations of the access and timeout block
`timescale 1ns/1ps
module tsat_chk #(
  parameter longint TIMEOUT_CYC = 50,
  parameter longint CONV_CYC = 40
) (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic SDA_IN,
  input wire logic BUS_BUSY_IN,
  input wire logic SHUTDOWN_IN,
  input wire logic [8:0] SAMPLE_IN,
  input wire logic [8:0] TEMP_OUT,
  input wire logic CONV_DONE_OUT,
  input wire logic OVER_TEMP_OUT,
  input wire logic BUS_RESET_OUT
);
  longint low_cnt, gap_cnt;
  logic fired, b1;
  // raw low time, quiet time since last commit or access end
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      low_cnt <= 0;
      gap_cnt <= 0;
      fired <= 1'b0;
      b1 <= 1'b0;
    end else begin
      low_cnt <= (SDA_IN || SHUTDOWN_IN) ? 0 : low_cnt + 1;
      gap_cnt <= (CONV_DONE_OUT || (b1 && !BUS_BUSY_IN)) ? 0 : gap_cnt + 1;
      fired <= BUS_RESET_OUT ? 1'b1 : (SDA_IN ? 1'b0 : fired);
      b1 <= BUS_BUSY_IN;
    end
  end
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);
  temp_hold_a: assert property (!CONV_DONE_OUT |-> $stable(TEMP_OUT))
    else $error("result moved without a commit");
  done_value_a: assert property (CONV_DONE_OUT |-> TEMP_OUT == $past(SAMPLE_IN))
    else $error("commit stored the wrong sample");
  busy_abort_a: assert property (BUS_BUSY_IN [*6] |-> !CONV_DONE_OUT)
    else $error("commit during an access");
  conv_gap_a: assert property (CONV_DONE_OUT |-> gap_cnt >= CONV_CYC - 1)
    else $error("commit before a full conversion");
  conv_due_a: assert property (!b1 && !BUS_BUSY_IN |-> gap_cnt <= CONV_CYC + 8)
    else $error("conversion not restarted");
  timeout_a: assert property (BUS_RESET_OUT |-> low_cnt >= TIMEOUT_CYC)
    else $error("bus reset too early");
  timeout_due_a: assert property (low_cnt == TIMEOUT_CYC + 8 |-> fired)
    else $error("bus reset missing");
  trip_commit_a: assert property ($rose(OVER_TEMP_OUT) |-> CONV_DONE_OUT)
    else $error("over-temperature set between commits");
  cover property (CONV_DONE_OUT);
  cover property (BUS_RESET_OUT);
  cover property (OVER_TEMP_OUT);
endmodule
bind tsat_top tsat_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .CONV_CYC(CONV_CYC))
  chk (.*);

// file: verification/tsat_top_tb.sv
// testbench: scenarios for the access and timeout block
`timescale 1ns/1ps
module tsat_top_tb;
  localparam longint TO = 50;
  localparam longint CV = 40;
  logic clk, rstn, sda, busy, shut, lwe, fwe, done, ot, brst;
  logic [2:0] fcnt;
  logic [8:0] samp, olim, hlim, temp, olo, hlo;
  int mismatches, total_checks, cycles, pulses;
  tsat_top #(.TIMEOUT_CYC(TO), .CONV_CYC(CV)) dut (.CLOCK_IN(clk),
    .RSTN_IN(rstn), .SDA_IN(sda), .BUS_BUSY_IN(busy), .SHUTDOWN_IN(shut),
    .SAMPLE_IN(samp), .LIMIT_WE_IN(lwe), .OVER_LIMIT_IN(olim),
    .HYST_LIMIT_IN(hlim), .FAULT_WE_IN(fwe), .FAULT_COUNT_IN(fcnt),
    .TEMP_OUT(temp), .OVER_LIMIT_OUT(olo), .HYST_LIMIT_OUT(hlo),
    .CONV_DONE_OUT(done), .OVER_TEMP_OUT(ot), .BUS_RESET_OUT(brst));
  tsat_host host (.clk_in(clk), .sda_out(sda), .busy_out(busy));
  task automatic check(input string what, input logic [8:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // bounded wait for a fresh commit, sampled away from the edge; the
  // leading negedge keeps a pulse from the last edge from being reused
  task automatic wait_done();
    @(negedge clk);
    for (int n = 0; n < 200 && done !== 1'b1; n++) @(negedge clk);
    check("conv_done", done, 9'h001);
  endtask
  task automatic t_convert();
    check("over_limit", olo, 9'h0a0);
    check("hyst_limit", hlo, 9'h096);
    wait_done();
    check("temp", temp, 9'h032);
  endtask
  // accesses closer than one conversion starve the result
  task automatic t_starve();
    wait_done();
    @(posedge clk) samp <= 9'h1ce;
    repeat (4) host.access(8, 20);
    host.access(120, 0);
    check("temp", temp, 9'h032);
    check("pulses", 9'(pulses), 9'h000);
    wait_done();
    check("temp", temp, 9'h1ce);
  endtask
  // three in a row needed; an in-between value restarts the run
  task automatic t_queue();
    logic [8:0] s [10] = '{9'h0fa, 9'h0fa, 9'h0fa, 9'h050, 9'h0fa,
                           9'h0fa, 9'h0c3, 9'h0fa, 9'h0fa, 9'h0fa};
    logic e [10] = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 1};
    @(posedge clk) {lwe, fwe, olim, hlim, fcnt} <= {2'b11, 18'h190be, 3'h3};
    @(posedge clk) {lwe, fwe} <= 2'b00;
    @(negedge clk);
    check("over_limit", olo, 9'h0c8);
    check("hyst_limit", hlo, 9'h0be);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) samp <= s[i];
      wait_done();
      check("over_temp", ot, e[i]);
    end
  endtask
  task automatic t_timeout();
    host.stick(TO - 20);
    repeat (10) @(posedge clk);
    check("pulses", 9'(pulses), 9'h000);
    host.stick(TO + 10);
    repeat (10) @(posedge clk);
    check("pulses", 9'(pulses), 9'h001);
    shut <= 1'b1;
    host.stick(TO + 10);
    repeat (10) @(posedge clk);
    check("pulses", 9'(pulses), 9'h001);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // pulse tally and hang guard
  always @(posedge clk) begin
    cycles++;
    if (brst === 1'b1) pulses++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {rstn, shut, lwe, fwe, fcnt} = 7'h01;
    {samp, olim, hlim} = {9'h032, 9'h0a0, 9'h096};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_convert();
    t_starve();
    t_queue();
    t_timeout();
    conclude();
  end
endmodule
